// file: hw/pcsl_pkg.sv
/*
 * Package for the peripheral clock select and LED burst clock block:
 * register offsets, field positions, reset values and source codes.
 * Assumes a 32-bit register port with byte offsets.
 */
package pcsl_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  PCSL_OFS_PERIPH_SEL  = 8'h2C;
  localparam logic [7:0]  PCSL_OFS_LED_CFG     = 8'h30;
  localparam logic [7:0]  PCSL_OFS_BOUNCE      = 8'h34;
  localparam logic [31:0] PCSL_RST_PERIPH_SEL  = 32'h0000_3800;
  localparam logic [31:0] PCSL_RST_LED_CFG     = 32'h7805_0000;
  localparam logic [31:0] PCSL_RST_BOUNCE      = 32'h0000_0000;
  localparam logic [31:0] PCSL_MASK_PERIPH_SEL = 32'hCE00_FDFF;
  localparam logic [31:0] PCSL_MASK_LED_CFG    = 32'hFFFF_0F0F;
  localparam logic [31:0] PCSL_MASK_BOUNCE     = 32'h00FF_0FF0;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int PCSL_BIT_ADV_TIMER_SEL   = 31;
  localparam int PCSL_BIT_BASIC_TIMER_SEL = 30;
  localparam int PCSL_BIT_LCD_SEL         = 27;
  localparam int PCSL_POS_ADC_WORK_SEL    = 25;
  localparam int PCSL_POS_ADC_ONE_MHZ_DIV = 11;
  localparam int PCSL_BIT_ADC_ONE_MHZ_SRC = 10;
  localparam int PCSL_POS_ADC_PLL_DIV     = 4;
  localparam int PCSL_POS_ADC_AHB_DIV     = 0;
  localparam int PCSL_POS_LED_PERIOD      = 24;
  localparam int PCSL_POS_LED_LOW         = 16;
  localparam int PCSL_POS_LED_DIV         = 8;
  localparam int PCSL_BIT_LED_DMA_EN      = 3;
  localparam int PCSL_BIT_LED_DONE        = 2;
  localparam int PCSL_BIT_LED_SRC         = 1;
  localparam int PCSL_BIT_LED_EN          = 0;
  localparam int PCSL_POS_BOUNCE_RESET    = 16;
  localparam int PCSL_POS_BOUNCE_DETECT   = 4;

  // ----------------------------------------------------------------
  // Source codes driven to the clock muxes
  // ----------------------------------------------------------------
  localparam logic [1:0] PCSL_TIMER_SRC_BUS    = 2'h0;
  localparam logic [1:0] PCSL_TIMER_SRC_BUS_X2 = 2'h1;
  localparam logic [1:0] PCSL_TIMER_SRC_ALT    = 2'h2;
  localparam logic [3:0] PCSL_LCD_DIV_INTERNAL = 4'h8;
  localparam logic [4:0] PCSL_LCD_DIV_EXTERNAL = 5'h10;

endpackage

// file: hw/pcsl_top.sv
/*
 * Peripheral clock selection, ADC prescaler decode, LED grey-scale
 * burst generator and ground-bounce monitor enables.
 * Toward the clock muxes only codes and divisor values leave; the muxes and
 * dividers that act on them sit outside, and a reserved work
 * clock code is passed to them untouched.
 * Assumes the oscillator ticks and bus prescaler flags come from logic
 * on clk_in, so no synchronisers are needed on them.
 */
// How it works
// - Advanced timer: bit 0 picks bus clock or double, bit 1 system clock.
// - Basic timer: bit 0 picks bus clock or double, bit 1 slow oscillator.
// - LCD takes internal oscillator over 8, or external oscillator over 16.
// - ADC work clock: 00 internal 24 MHz, 01 PLL, 10 AHB, 11 reserved.
// - ADC one-MHz divider divides by field value plus one.
// - ADC one-MHz source is internal oscillator at 0, external at 1.
// - ADC PLL clock gated when divider top bit is 0; 10000 undivided.
// - PLL codes 10001..11011 divide 2..256 in order, others by 256.
// - AHB divider codes 0..8 divide 1..32, higher codes by 32.
// - LED period count field holds N, 0 to 255.
// - LED low count field holds M, 0 to 255.
// - LED divider codes 1000..1101 give 32..160; 1110, 1111 give 64.
// - LED output held off while divider field top bit is 0.
// - DMA request issued at burst end only when its enable is set.
// - Complete flag sets when counted periods reach M plus N.
// - Writing 1 clears complete flag, writing 0 leaves it.
// - LED source is internal oscillator at 0, external at 1.
// - LED enable bit turns the burst generator on and off.
// - Eight bits allow each bounce monitor to request a reset.
// - Eight bits enable detection for each bounce monitor.
// - Selection register at 0x2C, reset value 0x00003800.
`timescale 1ns/1ps

module pcsl_top (
  // Clock, reset and enable
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        ce_in,
  // Register port
  input  wire logic [7:0]  addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [31:0] rdata_out,
  // Bus prescaler state
  input  wire logic        high_speed_prescale_one_in,
  input  wire logic        low_speed_prescale_one_in,
  // Oscillator ticks for the burst generator
  input  wire logic        internal_fast_tick_in,
  input  wire logic        external_fast_tick_in,
  // Clock mux controls
  output logic      [1:0]  advanced_timer_clock_sel_out,
  output logic      [1:0]  basic_timer_clock_sel_out,
  output logic             lcd_clock_select_out,
  output logic      [4:0]  lcd_clock_divide_out,
  output logic      [1:0]  adc_work_clock_select_out,
  output logic             adc_one_mhz_source_select_out,
  output logic      [5:0]  adc_one_mhz_divide_out,
  output logic             adc_pll_clock_enable_out,
  output logic      [8:0]  adc_pll_divide_out,
  output logic      [5:0]  adc_ahb_divide_out,
  // LED burst clock
  output logic             led_greyscale_clock_out,
  output logic             led_dma_request_out,
  // Ground-bounce monitors
  output logic      [3:0]  bounce_pos_reset_enable_out,
  output logic      [3:0]  bounce_neg_reset_enable_out,
  output logic      [3:0]  bounce_pos_detect_enable_out,
  output logic      [3:0]  bounce_neg_detect_enable_out
);
  import pcsl_pkg::*;

  // ----------------------------------------------------------------
  // Divider decoding
  // ----------------------------------------------------------------

  // Unused ADC codes fall back to the slowest divisor,
  // so a stray write cannot overclock the converter.

  // PLL prescaler; zero means the PLL-derived clock is gated
  function automatic logic [8:0] pll_divisor(input logic [4:0] code);
    logic [8:0] d;
    d = 9'h000;
    if (code[4]) begin
      unique case (code[3:0])
        4'h0:    d = 9'h001;
        4'h1:    d = 9'h002;
        4'h2:    d = 9'h004;
        4'h3:    d = 9'h006;
        4'h4:    d = 9'h008;
        4'h5:    d = 9'h00A;
        4'h6:    d = 9'h00C;
        4'h7:    d = 9'h010;
        4'h8:    d = 9'h020;
        4'h9:    d = 9'h040;
        4'hA:    d = 9'h080;
        default: d = 9'h100;
      endcase
    end
    return d;
  endfunction

  // AHB prescaler for the ADC
  function automatic logic [5:0] ahb_divisor(input logic [3:0] code);
    logic [5:0] d;
    unique case (code)
      4'h0:    d = 6'h01;
      4'h1:    d = 6'h02;
      4'h2:    d = 6'h04;
      4'h3:    d = 6'h06;
      4'h4:    d = 6'h08;
      4'h5:    d = 6'h0A;
      4'h6:    d = 6'h0C;
      4'h7:    d = 6'h10;
      default: d = 6'h20;
    endcase
    return d;
  endfunction

  // LED burst prescaler, top bit already checked by the caller
  function automatic logic [7:0] led_divisor(input logic [2:0] code);
    logic [7:0] d;
    unique case (code)
      3'h0:    d = 8'h20;
      3'h1:    d = 8'h28;
      3'h2:    d = 8'h32;
      3'h3:    d = 8'h40;
      3'h4:    d = 8'h50;
      3'h5:    d = 8'hA0;
      default: d = 8'h40;
    endcase
    return d;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  // One record holds all state: the three registers, read data,
  // the burst generator and registered copies of every decode.
  // The decode works on the next register value, so it lands with the write, and each
  // output then comes straight from a flip-flop and no decode
  // glitch can reach a clock mux.
  typedef struct packed {
    logic [31:0] periph_sel;
    logic [31:0] led_cfg;
    logic [31:0] bounce;
    logic [31:0] rdata;
    logic        en_seen;
    logic        running;
    logic [7:0]  div_cnt;
    logic [8:0]  pulse_cnt;
    logic        bclk;
    logic        dma_req;
    logic [1:0]  adv_sel;
    logic [1:0]  basic_sel;
    logic [4:0]  lcd_div;
    logic        pll_en;
    logic [8:0]  pll_div;
    logic [5:0]  ahb_div;
    logic [5:0]  one_mhz_div;
  } pcsl_state_type;

  // Registers take their reset words; everything else starts at zero
  localparam pcsl_state_type PCSL_STATE_RESET = '{
    periph_sel:  PCSL_RST_PERIPH_SEL,
    led_cfg:     PCSL_RST_LED_CFG,
    bounce:      PCSL_RST_BOUNCE,
    default:     '0
  };

  pcsl_state_type state;
  pcsl_state_type next_state;

  // Field views of the current configuration
  logic [7:0] led_period;
  logic [7:0] led_low;
  logic [3:0] led_div_code;
  logic       led_enable;
  logic       led_active;
  logic [7:0] led_div;
  logic [8:0] burst_total;
  logic       src_tick;
  logic       period_end;
  logic       burst_end;
  // A divisor of one (divider top bit clear) only occurs while
  // led_active is low, so the stepping branch never runs on it and
  // the divider count is left alone.

  // Burst sizing and source pick
  // Nine bits for M plus N, so 255 + 255 cannot wrap;
  // the source pick follows its select bit at once, even mid-burst
  always_comb begin
    led_period   = state.led_cfg[PCSL_POS_LED_PERIOD +: 8];
    led_low      = state.led_cfg[PCSL_POS_LED_LOW +: 8];
    led_div_code = state.led_cfg[PCSL_POS_LED_DIV +: 4];
    led_enable   = state.led_cfg[PCSL_BIT_LED_EN];
    led_active   = led_enable && led_div_code[3];
    led_div      = led_div_code[3] ? led_divisor(led_div_code[2:0]) : 8'h01;
    burst_total  = {1'b0, led_period} + {1'b0, led_low};
    src_tick     = state.led_cfg[PCSL_BIT_LED_SRC] ?
                   external_fast_tick_in : internal_fast_tick_in;
    period_end   = state.running && src_tick && (state.div_cnt == led_div - 8'h01);
    burst_end    = period_end && (state.pulse_cnt + 9'h001 >= burst_total);
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------

  // Register writes, burst generator and decoded mux controls in one pass
  always_comb begin
    logic done_set;
    logic done_clr;
    logic start;
    done_set   = 1'b0;
    done_clr   = 1'b0;
    start      = 1'b0;
    next_state = state;
    next_state.dma_req = 1'b0;

    // Software writes; reserved bits stay zero
    if (wr_in) begin
      unique case (addr_in)
        PCSL_OFS_PERIPH_SEL: begin
          next_state.periph_sel = wdata_in & PCSL_MASK_PERIPH_SEL;
        end
        PCSL_OFS_LED_CFG: begin
          next_state.led_cfg = (wdata_in & PCSL_MASK_LED_CFG)
                             & ~(32'h0000_0001 << PCSL_BIT_LED_DONE);
          next_state.led_cfg[PCSL_BIT_LED_DONE] = state.led_cfg[PCSL_BIT_LED_DONE];
          // The done bit keeps its value here; it settles further down
          done_clr = wdata_in[PCSL_BIT_LED_DONE];
        end
        PCSL_OFS_BOUNCE: begin
          next_state.bounce = wdata_in & PCSL_MASK_BOUNCE;
        end
        default: begin
        end
      endcase
    end

    // Reads answer one cycle later; unmapped offsets read zero
    // rather than an old word, so a wrong address shows at once
    if (rd_in) begin
      unique case (addr_in)
        PCSL_OFS_PERIPH_SEL: next_state.rdata = state.periph_sel;
        PCSL_OFS_LED_CFG:    next_state.rdata = state.led_cfg;
        PCSL_OFS_BOUNCE:     next_state.rdata = state.bounce;
        default:             next_state.rdata = 32'h0000_0000;
      endcase
    end

    // A fresh enable starts a new burst from a cleared count.
    // The detector resets low and the generator is off after
    // reset, so leaving reset never starts a burst by itself.
    next_state.en_seen = led_active;
    if (led_active && !state.en_seen) begin
      start = 1'b1;
      next_state.div_cnt   = 8'h00;
      next_state.pulse_cnt = 9'h000;
      next_state.running   = 1'b1;
      if (burst_total == 9'h000) begin
        next_state.running = 1'b0;
        done_set = 1'b1;
        next_state.dma_req = state.led_cfg[PCSL_BIT_LED_DMA_EN];
      end
    end

    // Generator steps once per source tick while running.
    // A tick in the start cycle is dropped: the count was just
    // cleared and the first high phase is already under way.
    if (!led_active) begin
      next_state.running = 1'b0;
    end else if (!start && state.running && src_tick) begin
      if (period_end) begin
        next_state.div_cnt   = 8'h00;
        next_state.pulse_cnt = state.pulse_cnt + 9'h001;
      end else begin
        next_state.div_cnt = state.div_cnt + 8'h01;
      end
      if (burst_end) begin
        next_state.running = 1'b0;
        done_set = 1'b1;
        next_state.dma_req = state.led_cfg[PCSL_BIT_LED_DMA_EN];
      end
    end

    // Period pulses first, then the low-level periods; every legal
    // divisor is even, so the high and low halves are equal
    next_state.bclk = next_state.running
                   && (next_state.pulse_cnt < {1'b0, led_period})
                   && (next_state.div_cnt < {1'b0, led_div[7:1]});

    // A completion in the clearing cycle wins over the clear,
    // so polling software cannot miss a finished burst
    if (done_set) begin
      next_state.led_cfg[PCSL_BIT_LED_DONE] = 1'b1;
    end else if (done_clr) begin
      next_state.led_cfg[PCSL_BIT_LED_DONE] = 1'b0;
    end

    // Timer mux codes from selects and bus prescalers.
    // The prescaler flags are sampled every cycle, so a bus
    // prescaler change reaches the code one cycle later.
    if (next_state.periph_sel[PCSL_BIT_ADV_TIMER_SEL]) begin
      next_state.adv_sel = PCSL_TIMER_SRC_ALT;
    end else begin
      next_state.adv_sel = high_speed_prescale_one_in ?
                           PCSL_TIMER_SRC_BUS : PCSL_TIMER_SRC_BUS_X2;
    end
    if (next_state.periph_sel[PCSL_BIT_BASIC_TIMER_SEL]) begin
      next_state.basic_sel = PCSL_TIMER_SRC_ALT;
    end else begin
      next_state.basic_sel = low_speed_prescale_one_in ?
                             PCSL_TIMER_SRC_BUS : PCSL_TIMER_SRC_BUS_X2;
    end

    // ADC and LCD divider values
    next_state.lcd_div = next_state.periph_sel[PCSL_BIT_LCD_SEL] ?
                         PCSL_LCD_DIV_EXTERNAL : {1'b0, PCSL_LCD_DIV_INTERNAL};
    next_state.pll_div = pll_divisor(next_state.periph_sel[PCSL_POS_ADC_PLL_DIV +: 5]);
    next_state.pll_en  = next_state.periph_sel[PCSL_POS_ADC_PLL_DIV + 4];
    next_state.ahb_div = ahb_divisor(next_state.periph_sel[PCSL_POS_ADC_AHB_DIV +: 4]);
    next_state.one_mhz_div = {1'b0, next_state.periph_sel[PCSL_POS_ADC_ONE_MHZ_DIV +: 5]}
                           + 6'h01;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------

  // Clock enable low freezes every field, flags included; a burst
  // paused this way resumes where it stopped. Decoded outputs read
  // zero in reset and take their values at the first enabled edge.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= PCSL_STATE_RESET;
    end else if (ce_in) begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------

  // All outputs are flip-flop fields; the work clock code passes raw
  // so a reserved code reaches the mux unchanged, which treats it as off
  assign rdata_out                     = state.rdata;
  assign advanced_timer_clock_sel_out  = state.adv_sel;
  assign basic_timer_clock_sel_out     = state.basic_sel;
  assign lcd_clock_select_out          = state.periph_sel[PCSL_BIT_LCD_SEL];
  assign lcd_clock_divide_out          = state.lcd_div;
  assign adc_work_clock_select_out     = state.periph_sel[PCSL_POS_ADC_WORK_SEL +: 2];
  assign adc_one_mhz_source_select_out = state.periph_sel[PCSL_BIT_ADC_ONE_MHZ_SRC];
  assign adc_one_mhz_divide_out        = state.one_mhz_div;
  assign adc_pll_clock_enable_out      = state.pll_en;
  assign adc_pll_divide_out            = state.pll_div;
  assign adc_ahb_divide_out            = state.ahb_div;
  assign led_greyscale_clock_out       = state.bclk;
  assign led_dma_request_out           = state.dma_req;
  // Bounce enables are plain register bits; the monitors
  // and the reset request path lie outside this block
  assign bounce_pos_reset_enable_out   = state.bounce[PCSL_POS_BOUNCE_RESET + 4 +: 4];
  assign bounce_neg_reset_enable_out   = state.bounce[PCSL_POS_BOUNCE_RESET +: 4];
  assign bounce_pos_detect_enable_out  = state.bounce[PCSL_POS_BOUNCE_DETECT + 4 +: 4];
  assign bounce_neg_detect_enable_out  = state.bounce[PCSL_POS_BOUNCE_DETECT +: 4];

endmodule

// file: verification/pcsl_properties.sv
/*
 * Checker for the clock select block: port-level timing and decode relations.
 * Assumes it is bound to pcsl_top with ce_in held high by the bench.
 */
`timescale 1ns/1ps
module pcsl_properties (
  // Clock and reset
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  // Observed inputs
  input wire logic [7:0]  addr_in,
  input wire logic        rd_in,
  input wire logic        high_speed_prescale_one_in,
  input wire logic        low_speed_prescale_one_in,
  // Observed outputs
  input wire logic [31:0] rdata_out,
  input wire logic [1:0]  advanced_timer_clock_sel_out,
  input wire logic [1:0]  basic_timer_clock_sel_out,
  input wire logic        lcd_clock_select_out,
  input wire logic [4:0]  lcd_clock_divide_out,
  input wire logic [5:0]  adc_one_mhz_divide_out,
  input wire logic        adc_pll_clock_enable_out,
  input wire logic [8:0]  adc_pll_divide_out,
  input wire logic [5:0]  adc_ahb_divide_out,
  input wire logic        led_dma_request_out
);
  // ----------------------------------------------------------------
  // Settle counter: decoded outputs are zero until the first edge
  // ----------------------------------------------------------------
  logic [1:0] up;
  wire        live = (up == 2'h3);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      up <= 2'h0;
    end else if (up != 2'h3) begin
      up <= up + 2'h1;
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  a_adv_timer_src: assert property (live && advanced_timer_clock_sel_out != 2'h2 |->
    advanced_timer_clock_sel_out == ($past(high_speed_prescale_one_in) ? 2'h0 : 2'h1))
    else $error("advanced timer source does not follow the prescaler flag");
  a_basic_timer_src: assert property (live && basic_timer_clock_sel_out != 2'h2 |->
    basic_timer_clock_sel_out == ($past(low_speed_prescale_one_in) ? 2'h0 : 2'h1))
    else $error("basic timer source does not follow the prescaler flag");
  a_lcd_div_pair: assert property (live |->
    lcd_clock_divide_out == (lcd_clock_select_out ? 5'h10 : 5'h08))
    else $error("lcd divide does not match its source");
  a_one_mhz_range: assert property (live |->
    adc_one_mhz_divide_out inside {[6'h01:6'h20]})
    else $error("one MHz divide out of range");
  a_pll_gate_zero: assert property (live && !adc_pll_clock_enable_out |->
    adc_pll_divide_out == 9'h000)
    else $error("gated pll clock still shows a divisor");
  a_pll_div_set: assert property (live && adc_pll_clock_enable_out |->
    adc_pll_divide_out inside {1, 2, 4, 6, 8, 10, 12, 16, 32, 64, 128, 256})
    else $error("pll divisor not a legal value");
  a_ahb_div_set: assert property (live |->
    adc_ahb_divide_out inside {1, 2, 4, 6, 8, 10, 12, 16, 32})
    else $error("ahb divisor not a legal value");
  a_dma_one_cycle: assert property (led_dma_request_out |=> !led_dma_request_out)
    else $error("dma request longer than one cycle");
  a_unmapped_zero: assert property (live && rd_in &&
    !(addr_in inside {8'h2C, 8'h30, 8'h34}) |=> rdata_out == 32'h0000_0000)
    else $error("unmapped read returned data");
endmodule

bind pcsl_top pcsl_properties u_props (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .rd_in(rd_in),
  .high_speed_prescale_one_in(high_speed_prescale_one_in),
  .low_speed_prescale_one_in(low_speed_prescale_one_in), .rdata_out(rdata_out),
  .advanced_timer_clock_sel_out(advanced_timer_clock_sel_out),
  .basic_timer_clock_sel_out(basic_timer_clock_sel_out),
  .lcd_clock_select_out(lcd_clock_select_out), .lcd_clock_divide_out(lcd_clock_divide_out),
  .adc_one_mhz_divide_out(adc_one_mhz_divide_out),
  .adc_pll_clock_enable_out(adc_pll_clock_enable_out),
  .adc_pll_divide_out(adc_pll_divide_out), .adc_ahb_divide_out(adc_ahb_divide_out),
  .led_dma_request_out(led_dma_request_out));

// file: verification/pcsl_periph_model.sv
/*
 * Far-side model: oscillator ticks toward the block, burst pulse counter.
 * Assumes one clock domain shared with the block.
 */
`timescale 1ns/1ps
module pcsl_periph_model (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  // Burst clock from the block
  input  wire logic bclk_in,
  // Oscillator ticks
  output logic      int_tick_out,
  output logic      ext_tick_out,
  // Rising edges of the burst clock seen so far
  output int        pulses_out
);
  logic [1:0] ph;
  logic       last;
  // Internal oscillator never stops, so a source switch is always safe
  assign int_tick_out = 1'b1;
  // External oscillator ticks every third cycle to test a slower source
  assign ext_tick_out = (ph == 2'h2);
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ph <= 2'h0;
      last <= 1'b0;
      pulses_out <= 0;
    end else begin
      ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
      last <= bclk_in;
      if (bclk_in && !last) pulses_out <= pulses_out + 1;
    end
  end
endmodule

// file: verification/test_pcsl_top.sv
/*
 * Self-checking bench for pcsl_top: register port, decode and burst clock.
 * Assumes ce_in held high and ticks from the far-side model.
 */
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
  $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module test_pcsl_top;
  import pcsl_pkg::*;
  logic clk_in = 0, rst_n_in = 0, wr_in = 0, rd_in = 0, hs = 0, ls = 0, it, et, bclk, dma;
  logic [7:0]  addr_in = 8'h00;
  logic [31:0] wdata_in = 32'h0000_0000, rdata_out, v;
  logic [1:0]  adv, bas, wsel;
  logic [4:0]  lcd_div;
  logic [5:0]  one_div, ahb_div;
  logic [8:0]  pll_div;
  logic [3:0]  prs, nrs, pdt, ndt;
  logic        lcd_sel, one_src, pll_en;
  int seed = 35596, bad_count = 0, cmp_count = 0, pulses, i, p;
  // ----------------------------------------------------------------
  // Clock, random prescaler flags, design and far side
  // ----------------------------------------------------------------
  always #12.5 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    hs <= 1'($random(seed));
    ls <= 1'($random(seed));
  end
  pcsl_top dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(1'b1), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .high_speed_prescale_one_in(hs), .low_speed_prescale_one_in(ls),
    .internal_fast_tick_in(it), .external_fast_tick_in(et),
    .advanced_timer_clock_sel_out(adv), .basic_timer_clock_sel_out(bas),
    .lcd_clock_select_out(lcd_sel), .lcd_clock_divide_out(lcd_div),
    .adc_work_clock_select_out(wsel), .adc_one_mhz_source_select_out(one_src),
    .adc_one_mhz_divide_out(one_div), .adc_pll_clock_enable_out(pll_en),
    .adc_pll_divide_out(pll_div), .adc_ahb_divide_out(ahb_div),
    .led_greyscale_clock_out(bclk), .led_dma_request_out(dma),
    .bounce_pos_reset_enable_out(prs), .bounce_neg_reset_enable_out(nrs),
    .bounce_pos_detect_enable_out(pdt), .bounce_neg_detect_enable_out(ndt));
  pcsl_periph_model peer (.clk_in(clk_in), .rst_n_in(rst_n_in), .bclk_in(bclk),
    .int_tick_out(it), .ext_tick_out(et), .pulses_out(pulses));
  // ----------------------------------------------------------------
  // Expected divisors
  // ----------------------------------------------------------------
  function automatic int pll(input logic [4:0] c);
    int t [12] = '{1, 2, 4, 6, 8, 10, 12, 16, 32, 64, 128, 256};
    if (!c[4]) return 0;
    return (c[3:0] > 4'hB) ? 256 : t[c[3:0]];
  endfunction
  function automatic int ahb(input logic [3:0] c);
    int t [9] = '{1, 2, 4, 6, 8, 10, 12, 16, 32};
    return (c > 4'h8) ? 32 : t[c];
  endfunction
  function automatic int ldiv(input logic [3:0] c);
    int t [6] = '{32, 40, 50, 64, 80, 160};
    return (c > 4'hD) ? 64 : t[c - 4'h8];
  endfunction
  // ----------------------------------------------------------------
  // Bus tasks: strobes change right after an edge, one cycle long
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    @(negedge clk_in);
    `CHK(rdata_out, e)
  endtask
  task automatic note(input string s);
    $display("Test %s finished", s);
  endtask
  task automatic chk_sel(input logic [31:0] s);
    `CHK(adv[1], s[31])
    `CHK(bas[1], s[30])
    `CHK(lcd_sel, s[27])
    `CHK(lcd_div, s[27] ? 5'h10 : 5'h08)
    `CHK(wsel, s[26:25])
    `CHK(one_div, {1'b0, s[15:11]} + 6'h01)
    `CHK(one_src, s[10])
    `CHK(pll_en, s[8])
    `CHK(pll_div, 9'(pll(s[8:4])))
    `CHK(ahb_div, 6'(ahb(s[3:0])))
  endtask
  // One burst over a fixed window, then done flag handling
  task automatic burst(input logic [3:0] c, input logic [7:0] n, m, input logic s, de,
                       input int hi_e, pul_e, input logic d);
    int hi, dn, p0, k;
    p0 = pulses;
    hi = 0;
    dn = 0;
    wr(8'h30, {n, m, 4'h0, c, 4'h0, de, 1'b0, s, 1'b1});
    for (k = 0; k < 600; k++) begin
      @(negedge clk_in);
      if (bclk === 1'b1) hi++;
      if (dma === 1'b1) dn++;
    end
    `CHK(hi, hi_e)
    `CHK(pulses - p0, pul_e)
    `CHK(dn, int'(de & d))
    rd(8'h30, {n, m, 4'h0, c, 4'h0, de, d, s, 1'b1});
    wr(8'h30, 32'h0000_0000);
    rd(8'h30, {29'h0, d, 2'h0});
    wr(8'h30, 32'h0000_0004);
    rd(8'h30, 32'h0000_0000);
  endtask
  task automatic print_verdict;
    $display("Comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rd(8'h2C, PCSL_RST_PERIPH_SEL);
    rd(8'h30, PCSL_RST_LED_CFG);
    rd(8'h34, PCSL_RST_BOUNCE);
    rd(8'h38, 32'h0000_0000);
    note("reset");
    // Every pll and ahb code, random other fields
    for (i = 0; i < 32; i++) begin
      v = $random(seed) & PCSL_MASK_PERIPH_SEL;
      v[8:4] = i[4:0];
      v[3:0] = i[3:0];
      wr(8'h2C, v);
      rd(8'h2C, v);
      chk_sel(v);
    end
    note("select");
    p = pulses;
    for (i = 0; i < 8; i++) begin
      v = $random(seed);
      wr(8'h34, v);
      rd(8'h34, v & PCSL_MASK_BOUNCE);
      `CHK({prs, nrs}, v[23:16])
      `CHK({pdt, ndt}, v[11:4])
      v = $random(seed) & 32'hFFFF_FFFA;
      wr(8'h30, v);
      rd(8'h30, v & PCSL_MASK_LED_CFG);
    end
    `CHK(pulses, p)
    note("fields");
    for (i = 8; i < 16; i++) begin
      burst(i[3:0], 8'h01, 8'h00, 1'b0, i[0], ldiv(i[3:0]) / 2, 1, 1'b1);
    end
    burst(4'h8, 8'h02, 8'h03, 1'b1, 1'b1, 96, 2, 1'b1);
    burst(4'h7, 8'h01, 8'h00, 1'b0, 1'b1, 0, 0, 1'b0);
    burst(4'h8, 8'h00, 8'h00, 1'b0, 1'b1, 0, 0, 1'b1);
    note("burst");
    print_verdict;
  end
endmodule
